// [include/adcts_defines.svh]
`ifndef ADCTS_DEFINES_SVH
`define ADCTS_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADCTS_ADDR_W 4
`define ADCTS_OFF_REF_STATUS 4'h0
`define ADCTS_OFF_SUSP_TRIG 4'h1
`define ADCTS_OFF_INT_STATUS 4'h2
`define ADCTS_OFF_INT_MASK 4'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ADCTS_BIT_REF_READY 15
`define ADCTS_BIT_REF_ERROR 14
`define ADCTS_SAMC_HI 9
`define ADCTS_SAMC_W 10
`define ADCTS_REFERENCE_SELECT_HI 15
`define ADCTS_REFERENCE_SELECT_LO 13
`define ADCTS_BIT_SUSPEND 12
`define ADCTS_BIT_SUSP_IE 11
`define ADCTS_BIT_SUSP_RDY 10
`define ADCTS_BIT_DIRECT_SAMP 9
`define ADCTS_BIT_CH_TRIG 8
`define ADCTS_BIT_LVL_TRIG 7
`define ADCTS_BIT_COM_TRIG 6
`define ADCTS_CHSEL_HI 5
`define ADCTS_CHSEL_W 6
`define ADCTS_EVT_W 2
`define ADCTS_EVT_SUSP 0
`define ADCTS_EVT_REFERENCE_ERROR_FLAG 1

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define ADCTS_RESET_16 16'h0000
`define ADCTS_REFERENCE_SELECT_SUPPLY 3'h0
`define ADCTS_SAMC_EXTRA 11'h003
`define ADCTS_CNT_W 11

`endif

// [include/adcts_pkg.sv]
package adcts_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } adcts_bus_t;

   typedef struct packed {
      logic ch_trig;
      logic [5:0] ch_sel;
      logic com_trig;
      logic lvl_trig;
      logic block;
   } adcts_trig_t;

   typedef enum logic [1:0] {
      ADCTS_SH_IDLE = 2'b00,
      ADCTS_SH_TIMED = 2'b01,
      ADCTS_SH_DIRECT = 2'b11
   } adcts_samp_t;

endpackage

// [src/adcts_ctrl.sv]
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adcts_defines.svh"
// Notes on behaviour
// - Reference-ready flag reads high while the band gap is ready.
// - Reference-error flag sets on band gap loss while the module is on.
// - A 10-bit sample-time count sets shared sampling; all ones is 1025.
// - Reference select 000 picks the supply rails; other codes unused.
// - While suspend is set, every new trigger to all cores is blocked.
// - Suspended-ready sets only when suspended and no conversion runs.
// - With its enable and mask bit 0 set, a suspended-ready rise raises the interrupt.
// - Direct sampling keeps the selected input on the shared core.
// - Without direct sampling the shared core times sampling by count.
// - Channel trigger fires once and clears itself on the next cycle.
// - Level common trigger fires continuously while set.
// - Common trigger fires once and clears itself on the next cycle.
// - Channel select names the input of channel trigger and direct mode.
module adcts_ctrl (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic BANDGAP_READY,
   input wire logic MODULE_ON,
   input wire logic CORE_BUSY,
   input wire logic CORE_CLK_EN,
   output logic SINGLE_CHANNEL_SOFT_TRIGGER,
   output logic [5:0] SOFT_TRIGGER_CHANNEL_SELECT,
   output logic COMMON_SOFT_TRIGGER,
   output logic LEVEL_COMMON_SOFT_TRIGGER,
   output logic TRIGGER_BLOCK,
   output logic SHARED_SAMPLE,
   output logic [5:0] SHARED_SAMPLE_CHANNEL,
   output logic [2:0] REFERENCE_SELECT,
   output logic IRQ
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_s1_q;
   logic rst_n;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   adcts_pkg::adcts_bus_t bus;
   assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic ref_ready_q, ref_ready_d;
   logic ref_error_q, ref_error_d;
   logic [9:0] samc_q, samc_d;
   logic [2:0] reference_select_q, reference_select_d;
   logic suspend_q, suspend_d;
   logic susp_ie_q, susp_ie_d;
   logic susp_rdy_q, susp_rdy_d;
   logic direct_q, direct_d;
   logic ch_trig_q, ch_trig_d;
   logic lvl_trig_q, lvl_trig_d;
   logic com_trig_q, com_trig_d;
   logic [5:0] chsel_q, chsel_d;
   logic [1:0] int_stat_q, int_stat_d;
   logic [1:0] int_mask_q, int_mask_d;
   logic [1:0] evt;
   logic w0, w1, w3, r2;

   assign w0 = bus.wr && hit(bus.addr, `ADCTS_OFF_REF_STATUS);
   assign w1 = bus.wr && hit(bus.addr, `ADCTS_OFF_SUSP_TRIG);
   assign w3 = bus.wr && hit(bus.addr, `ADCTS_OFF_INT_MASK);
   assign r2 = bus.rd && hit(bus.addr, `ADCTS_OFF_INT_STATUS);

   always_comb begin
      ref_ready_d = BANDGAP_READY;
      ref_error_d = ref_error_q | (MODULE_ON & ref_ready_q &
                    ~BANDGAP_READY);
      samc_d = samc_q;
      reference_select_d = reference_select_q;
      suspend_d = suspend_q;
      susp_ie_d = susp_ie_q;
      direct_d = direct_q;
      lvl_trig_d = lvl_trig_q;
      chsel_d = chsel_q;
      int_mask_d = int_mask_q;
      // Self-clearing single shots
      ch_trig_d = 1'b0;
      com_trig_d = 1'b0;
      if (w0) begin
         samc_d = bus.wdata[`ADCTS_SAMC_HI:0];
      end
      if (w1) begin
         reference_select_d = bus.wdata[`ADCTS_REFERENCE_SELECT_HI:`ADCTS_REFERENCE_SELECT_LO];
         suspend_d = bus.wdata[`ADCTS_BIT_SUSPEND];
         susp_ie_d = bus.wdata[`ADCTS_BIT_SUSP_IE];
         direct_d = bus.wdata[`ADCTS_BIT_DIRECT_SAMP];
         ch_trig_d = bus.wdata[`ADCTS_BIT_CH_TRIG];
         lvl_trig_d = bus.wdata[`ADCTS_BIT_LVL_TRIG];
         com_trig_d = bus.wdata[`ADCTS_BIT_COM_TRIG];
         chsel_d = bus.wdata[`ADCTS_CHSEL_HI:0];
      end
      if (w3) begin
         int_mask_d = bus.wdata[1:0];
      end
      susp_rdy_d = suspend_q & ~CORE_BUSY;
      evt = 2'b00;
      evt[`ADCTS_EVT_SUSP] = susp_rdy_d & ~susp_rdy_q & susp_ie_q;
      evt[`ADCTS_EVT_REFERENCE_ERROR_FLAG] = ref_error_d & ~ref_error_q;
      // Set wins over read-clear
      int_stat_d = (r2 ? 2'b00 : int_stat_q) | evt;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ref_ready_q <= 1'b0;
         ref_error_q <= 1'b0;
         samc_q <= 10'h000;
         reference_select_q <= `ADCTS_REFERENCE_SELECT_SUPPLY;
         suspend_q <= 1'b0;
         susp_ie_q <= 1'b0;
         susp_rdy_q <= 1'b0;
         direct_q <= 1'b0;
         ch_trig_q <= 1'b0;
         lvl_trig_q <= 1'b0;
         com_trig_q <= 1'b0;
         chsel_q <= 6'h00;
         int_stat_q <= 2'h0;
         int_mask_q <= 2'h0;
      end else begin
         ref_ready_q <= ref_ready_d;
         ref_error_q <= ref_error_d;
         samc_q <= samc_d;
         reference_select_q <= reference_select_d;
         suspend_q <= suspend_d;
         susp_ie_q <= susp_ie_d;
         susp_rdy_q <= susp_rdy_d;
         direct_q <= direct_d;
         ch_trig_q <= ch_trig_d;
         lvl_trig_q <= lvl_trig_d;
         com_trig_q <= com_trig_d;
         chsel_q <= chsel_d;
         int_stat_q <= int_stat_d;
         int_mask_q <= int_mask_d;
      end
   end

   // ------------------------------------------------------------
   // Shared core sampling timer
   // ------------------------------------------------------------
   adcts_pkg::adcts_samp_t samp_q, samp_d;
   logic [10:0] samp_cnt_q, samp_cnt_d;
   logic samp_start;
   assign samp_start = ch_trig_q & ~suspend_q;

   always_comb begin
      samp_d = samp_q;
      samp_cnt_d = samp_cnt_q;
      case (samp_q)
         adcts_pkg::ADCTS_SH_IDLE: begin
            if (direct_q) begin
               samp_d = adcts_pkg::ADCTS_SH_DIRECT;
            end else if (samp_start) begin
               samp_d = adcts_pkg::ADCTS_SH_TIMED;
               // All ones gives 1025 periods
               samp_cnt_d = {1'b0, samc_q} + `ADCTS_SAMC_EXTRA
                            - 11'h002;
            end
         end
         adcts_pkg::ADCTS_SH_TIMED: begin
            if (CORE_CLK_EN) begin
               if (samp_cnt_d == 11'h000) begin
                  samp_d = adcts_pkg::ADCTS_SH_IDLE;
               end else begin
                  samp_cnt_d = samp_cnt_q - 11'h001;
               end
            end
         end
         adcts_pkg::ADCTS_SH_DIRECT: begin
            if (!direct_q) begin
               samp_d = adcts_pkg::ADCTS_SH_IDLE;
            end
         end
         default: begin
            samp_d = adcts_pkg::ADCTS_SH_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= adcts_pkg::ADCTS_SH_IDLE;
         samp_cnt_q <= 11'h000;
      end else begin
         samp_q <= samp_d;
         samp_cnt_q <= samp_cnt_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs and read data
   // ------------------------------------------------------------
   adcts_pkg::adcts_trig_t trig_d, trig_q;
   logic [15:0] rdata_d;
   logic samp_out_d;
   logic irq_d;

   always_comb begin
      trig_d.block = suspend_q;
      trig_d.ch_trig = ch_trig_q & ~suspend_q;
      trig_d.ch_sel = chsel_q;
      trig_d.com_trig = com_trig_q & ~suspend_q;
      trig_d.lvl_trig = lvl_trig_q & ~suspend_q;
      samp_out_d = (samp_d != adcts_pkg::ADCTS_SH_IDLE);
      irq_d = |(int_stat_d & int_mask_q);
      rdata_d = `ADCTS_RESET_16;
      if (bus.rd) begin
         case (bus.addr)
            `ADCTS_OFF_REF_STATUS: begin
               rdata_d[`ADCTS_BIT_REF_READY] = ref_ready_q;
               rdata_d[`ADCTS_BIT_REF_ERROR] = ref_error_q;
               rdata_d[`ADCTS_SAMC_HI:0] = samc_q;
            end
            `ADCTS_OFF_SUSP_TRIG: begin
               rdata_d[`ADCTS_REFERENCE_SELECT_HI:`ADCTS_REFERENCE_SELECT_LO] = reference_select_q;
               rdata_d[`ADCTS_BIT_SUSPEND] = suspend_q;
               rdata_d[`ADCTS_BIT_SUSP_IE] = susp_ie_q;
               rdata_d[`ADCTS_BIT_SUSP_RDY] = susp_rdy_q;
               rdata_d[`ADCTS_BIT_DIRECT_SAMP] = direct_q;
               rdata_d[`ADCTS_BIT_CH_TRIG] = ch_trig_q;
               rdata_d[`ADCTS_BIT_LVL_TRIG] = lvl_trig_q;
               rdata_d[`ADCTS_BIT_COM_TRIG] = com_trig_q;
               rdata_d[`ADCTS_CHSEL_HI:0] = chsel_q;
            end
            `ADCTS_OFF_INT_STATUS: begin
               rdata_d[1:0] = int_stat_q;
            end
            `ADCTS_OFF_INT_MASK: begin
               rdata_d[1:0] = int_mask_q;
            end
            default: begin
               rdata_d = `ADCTS_RESET_16;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         trig_q <= '0;
         RDATA <= `ADCTS_RESET_16;
         SHARED_SAMPLE <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         trig_q <= trig_d;
         RDATA <= rdata_d;
         SHARED_SAMPLE <= samp_out_d;
         IRQ <= irq_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         SHARED_SAMPLE_CHANNEL <= 6'h00;
         REFERENCE_SELECT <= `ADCTS_REFERENCE_SELECT_SUPPLY;
      end else begin
         SHARED_SAMPLE_CHANNEL <= chsel_q;
         REFERENCE_SELECT <= reference_select_q;
      end
   end

   assign SINGLE_CHANNEL_SOFT_TRIGGER = trig_q.ch_trig;
   assign SOFT_TRIGGER_CHANNEL_SELECT = trig_q.ch_sel;
   assign COMMON_SOFT_TRIGGER = trig_q.com_trig;
   assign LEVEL_COMMON_SOFT_TRIGGER = trig_q.lvl_trig;
   assign TRIGGER_BLOCK = trig_q.block;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_ch_write;
      w1 && bus.wdata[`ADCTS_BIT_CH_TRIG] && !bus.wdata[`ADCTS_BIT_SUSPEND]
         && !suspend_q;
   endsequence

   property p_ch_pulse;
      @(posedge CLK_SYS) disable iff (!rst_n)
      s_ch_write |-> ##2 SINGLE_CHANNEL_SOFT_TRIGGER ##1
         !SINGLE_CHANNEL_SOFT_TRIGGER || $past(w1);
   endproperty
   a_ch_pulse: assert property (p_ch_pulse)
      else $error("Channel trigger not a single pulse");

   property p_ch_clear;
      @(posedge CLK_SYS) disable iff (!rst_n)
      ch_trig_q && !w1 |=> !ch_trig_q;
   endproperty
   a_ch_clear: assert property (p_ch_clear)
      else $error("Channel trigger bit did not self clear");

   property p_com_clear;
      @(posedge CLK_SYS) disable iff (!rst_n)
      com_trig_q && !w1 |=> !com_trig_q;
   endproperty
   a_com_clear: assert property (p_com_clear)
      else $error("Common trigger bit did not self clear");

   property p_block;
      @(posedge CLK_SYS) disable iff (!rst_n)
      $past(suspend_q) |-> !COMMON_SOFT_TRIGGER &&
         !SINGLE_CHANNEL_SOFT_TRIGGER && !LEVEL_COMMON_SOFT_TRIGGER;
   endproperty
   a_block: assert property (p_block)
      else $error("Trigger passed while suspended");

   property p_susp_rdy;
      @(posedge CLK_SYS) disable iff (!rst_n)
      susp_rdy_q |-> $past(suspend_q) && !$past(CORE_BUSY);
   endproperty
   a_susp_rdy: assert property (p_susp_rdy)
      else $error("Suspended ready set with work pending");

   property p_irq;
      @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(susp_rdy_q) && susp_ie_q && int_mask_q[0] |-> ##1 IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Suspend interrupt missing");

   property p_ref_err;
      @(posedge CLK_SYS) disable iff (!rst_n)
      MODULE_ON && ref_ready_q && !BANDGAP_READY |=> ref_error_q;
   endproperty
   a_ref_err: assert property (p_ref_err)
      else $error("Reference error not flagged");

   property p_ref_rdy;
      @(posedge CLK_SYS) disable iff (!rst_n)
      $past(rst_n) |-> ref_ready_q == $past(BANDGAP_READY);
   endproperty
   a_ref_rdy: assert property (p_ref_rdy)
      else $error("Reference ready does not follow band gap");

   property p_direct;
      @(posedge CLK_SYS) disable iff (!rst_n)
      direct_q [*2] |=> SHARED_SAMPLE;
   endproperty
   a_direct: assert property (p_direct)
      else $error("Direct sampling not held");

endmodule

// [testbench/adcts_cores_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Converter cores seen from the trigger side
// ---------------------------------------------------------------
module adcts_cores_model #(
   parameter int CONV_LEN = 6,
   parameter int CLK_DIV = 4
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic single_trig,
   input wire logic com_trig,
   input wire logic lvl_trig,
   input wire logic block,
   input wire logic stall,
   output logic core_busy,
   output logic core_clk_en
);
   int busy_cnt;
   int div_cnt;
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         busy_cnt <= 0;
         div_cnt <= 0;
         core_clk_en <= 1'b0;
      end else begin
         div_cnt <= (div_cnt == CLK_DIV - 1) ? 0 : div_cnt + 1;
         core_clk_en <= (div_cnt == CLK_DIV - 1);
         if ((single_trig || com_trig || lvl_trig) && !block) begin
            busy_cnt <= CONV_LEN;
         end else if (busy_cnt > 0 && !stall) begin
            busy_cnt <= busy_cnt - 1;
         end
      end
   end
   // Slow answer: stall keeps a conversion running
   assign core_busy = (busy_cnt > 0) || stall;
endmodule

// [testbench/adc_trigger_suspend_control_test.sv]
`timescale 1ns/1ps
module adc_trigger_suspend_control_test;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic bandgap_ready = 1'b1;
   logic module_on = 1'b0;
   logic stall = 1'b0;
   logic rd_seen = 1'b0;
   logic ch_prev = 1'b0;
   logic com_prev = 1'b0;
   logic core_busy, core_clk_en, ch_trig, com_trig, lvl_trig;
   logic trig_block, shared_sample, irq;
   logic [15:0] rdata;
   logic [5:0] ch_sel, samp_ch, ch, ch_exp;
   logic [2:0] ref_sel;
   logic [15:0] samc;
   logic [15:0] rd_q[$];
   logic [5:0] trig_q[$];
   int com_expect = 0;
   int failures = 0;
   int comparisons = 0;
   int seed = 32'hcd59;
   int n;

   always #5 clk_sys = ~clk_sys;

   adcts_ctrl adcts_ctrl_i (
      .CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .BANDGAP_READY(bandgap_ready),
      .MODULE_ON(module_on), .CORE_BUSY(core_busy),
      .CORE_CLK_EN(core_clk_en), .SINGLE_CHANNEL_SOFT_TRIGGER(ch_trig),
      .SOFT_TRIGGER_CHANNEL_SELECT(ch_sel), .COMMON_SOFT_TRIGGER(com_trig),
      .LEVEL_COMMON_SOFT_TRIGGER(lvl_trig), .TRIGGER_BLOCK(trig_block),
      .SHARED_SAMPLE(shared_sample), .SHARED_SAMPLE_CHANNEL(samp_ch),
      .REFERENCE_SELECT(ref_sel), .IRQ(irq)
   );

   adcts_cores_model adcts_cores_model_i (
      .CLK_SYS(clk_sys), .RSTN(rstn), .single_trig(ch_trig),
      .com_trig(com_trig), .lvl_trig(lvl_trig), .block(trig_block),
      .stall(stall), .core_busy(core_busy), .core_clk_en(core_clk_en)
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
      rd_q.push_back(exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
   endtask

   task automatic timed_len(input logic [15:0] code, input int lo,
      input int hi);
      int k;
      reg_wr(4'h0, code);
      trig_q.push_back(6'h05);
      reg_wr(4'h1, 16'h0105);
      k = 0;
      while (shared_sample !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      k = 0;
      while (shared_sample === 1'b1 && k < 5000) begin
         cyc(1);
         k++;
      end
      check("timed", 16'(k >= lo && k <= hi), 16'h0001);
   endtask

   // ---------------------------------------------------------------
   // Output monitor
   // ---------------------------------------------------------------
   always @(posedge clk_sys) rd_seen <= rd;
   always @(negedge clk_sys) begin
      if (rd_seen === 1'b1 && rd_q.size() > 0) begin
         check("rdata", rdata, rd_q.pop_front());
      end
      if (ch_trig === 1'b1) begin
         check("ch_len", {15'h0, ch_prev}, 16'h0);
         if (trig_q.size() == 0) begin
            check("ch_blocked", 16'h1, 16'h0);
         end else begin
            ch_exp = trig_q.pop_front();
            check("ch_sel", {10'h0, ch_sel}, {10'h0, ch_exp});
         end
      end
      if (com_trig === 1'b1) begin
         check("com_len", {15'h0, com_prev}, 16'h0);
         check("com_due", {15'h0, com_expect > 0}, 16'h1);
         com_expect--;
      end
      ch_prev = ch_trig;
      com_prev = com_trig;
   end

   initial begin
      #300000;
      failures++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(4);
      rstn <= 1'b1;
      cyc(4);
      reg_rd(4'h0, 16'h8000);
      reg_rd(4'h1, 16'h0000);
      reg_rd(4'h2, 16'h0000);
      reg_rd(4'h3, 16'h0000);
      reg_rd(4'h7, 16'h0000);
      check("reference_select", {13'h0, ref_sel}, 16'h0000);
      for (n = 0; n < 4; n++) begin
         samc = (n == 3) ? 16'h03FF : 16'($random(seed)) & 16'h03FF;
         reg_wr(4'h0, samc | 16'hC000);
         reg_rd(4'h0, samc | 16'h8000);
      end
      timed_len(16'h03FF, 4097, 4100);
      reg_wr(4'h0, 16'h0002);
      for (n = 0; n < 4; n++) begin
         ch = 6'($random(seed));
         trig_q.push_back(ch);
         reg_wr(4'h1, {10'h004, ch});
         cyc(2);
         reg_rd(4'h1, {10'h000, ch});
         cyc(20);
      end
      timed_len(16'h0002, 13, 16);
      reg_wr(4'h1, 16'h0212);
      cyc(14);
      check("direct", {9'h0, shared_sample, samp_ch}, 16'h0052);
      reg_wr(4'h1, 16'h0012);
      trig_q.push_back(6'h12);
      reg_wr(4'h1, 16'h0112);
      cyc(20);
      com_expect = 2;
      reg_wr(4'h1, 16'h0040);
      reg_wr(4'h1, 16'h0040);
      cyc(4);
      check("com_left", 16'(com_expect), 16'h0000);
      reg_rd(4'h1, 16'h0000);
      reg_wr(4'h1, 16'h0080);
      cyc(2);
      check("lvl_on", {15'h0, lvl_trig}, 16'h0001);
      reg_wr(4'h1, 16'h0000);
      cyc(2);
      check("lvl_off", {15'h0, lvl_trig}, 16'h0000);
      cyc(10);
      reg_wr(4'h3, 16'h0003);
      stall <= 1'b1;
      reg_wr(4'h1, 16'h1800);
      cyc(4);
      reg_rd(4'h1, 16'h1800);
      check("irq_busy", {15'h0, irq}, 16'h0000);
      check("block", {15'h0, trig_block}, 16'h0001);
      reg_wr(4'h1, 16'h1940);
      stall <= 1'b0;
      cyc(4);
      reg_rd(4'h1, 16'h1C00);
      check("irq_susp", {15'h0, irq}, 16'h0001);
      reg_rd(4'h2, 16'h0001);
      reg_rd(4'h2, 16'h0000);
      cyc(2);
      check("irq_clr", {15'h0, irq}, 16'h0000);
      reg_wr(4'h1, 16'h0400);
      reg_rd(4'h1, 16'h0000);
      reg_wr(4'h1, 16'h1000);
      cyc(4);
      reg_rd(4'h1, 16'h1400);
      reg_rd(4'h2, 16'h0000);
      reg_wr(4'h1, 16'h0000);
      reg_wr(4'h3, 16'h0001);
      module_on <= 1'b1;
      cyc(2);
      bandgap_ready <= 1'b0;
      cyc(4);
      reg_rd(4'h0, 16'h4002);
      check("irq_mask", {15'h0, irq}, 16'h0000);
      reg_wr(4'h3, 16'h0003);
      cyc(2);
      check("irq_err", {15'h0, irq}, 16'h0001);
      reg_rd(4'h2, 16'h0002);
      bandgap_ready <= 1'b1;
      cyc(4);
      check("irq_end", {15'h0, irq}, 16'h0000);
      reg_rd(4'h0, 16'hC002);
      cyc(4);
      check("left", 16'(trig_q.size() + rd_q.size()), 16'h0000);
      stop_test();
   end
endmodule
